// ==== hw/sync_slave_map.vh ====
// Register map, field positions and reset values of the synchronous slave serial port.
// Included by the port top and its shift engine; definitions only.
`ifndef SYNC_SLAVE_MAP_VH
`define SYNC_SLAVE_MAP_VH

// Word byte addresses on the register bus
`define ADDR_RX_STAT_CTRL 4'h0
`define ADDR_TX_HOLD 4'h1
`define ADDR_TX_STAT_CTRL 4'h2
`define ADDR_BAUD_LINE 4'h3
`define ADDR_DIV_HIGH 4'h4
`define ADDR_DIV_LOW 4'h5
`define ADDR_RX_HOLD 4'h6
`define ADDR_IRQ_CTRL 4'h7

// receive_status_control fields
`define RXC_SERIAL_PORT_ENABLE 7
`define RXC_RX9 6
`define RXC_SINGLE_RECEIVE_ENABLE 5
`define RXC_CONTINUOUS_RECEIVE_ENABLE 4
`define RXC_ADDEN 3
`define RXC_FERR 2
`define RXC_OERR 1
`define RXC_RECEIVE_NINTH_BIT 0

// transmit_status_control fields
`define TXC_CLOCK_SOURCE_SELECT 7
`define TXC_TX9 6
`define TXC_TRANSMIT_ENABLE 5
`define TXC_SYNC 4
`define TXC_SENDB 3
`define TXC_BRGH 2
`define TXC_SHIFT_REGISTER_EMPTY 1
`define TXC_TRANSMIT_NINTH_BIT 0

// Interrupt control register fields
`define IRQ_GIE 7
`define IRQ_PERIPHERAL_IRQ_ENABLE 6
`define IRQ_RCIE 5
`define IRQ_TXIE 4
`define IRQ_RCIF 1
`define IRQ_TXIF 0

// Reset values
`define RST_RX_STAT_CTRL 8'h00
`define RST_TX_STAT_CTRL 8'h02
`define RST_BAUD_LINE 8'h00
`define RST_DIVISOR 8'h00
`define RST_IRQ_CTRL 8'h00

// Shift frame lengths
`define BITS_EIGHT 4'h8
`define BITS_NINE 4'h9

`endif

// ==== hw/sync_shift_engine.v ====
// Shift engine: transmit and receive shift registers clocked by shift clock edges.
// Assumes the caller supplies one-cycle edge strobes of an already synchronised clock.
`timescale 1ns/1ps
`include "sync_slave_map.vh"

module sync_shift_engine (
    input wire clk,
    input wire rst,
    // Edge strobes and data pin
    input wire rise_stb,
    input wire fall_stb,
    input wire data_in,
    // Transmit side
    input wire tx_active,
    input wire tx_load,
    input wire [8:0] tx_word,
    input wire tx_nine,
    output reg tx_out,
    output wire tx_busy,
    output reg tx_done,
    // Receive side
    input wire rx_active,
    input wire rx_nine,
    output reg [8:0] rx_word,
    output reg rx_done
);

reg [8:0] tsr_reg;
reg [3:0] tx_cnt_reg;
reg [8:0] rsr_reg;
reg [3:0] rx_cnt_reg;
wire [3:0] tx_len;
wire [3:0] rx_len;

assign tx_len = tx_nine ? `BITS_NINE : `BITS_EIGHT;
assign rx_len = rx_nine ? `BITS_NINE : `BITS_EIGHT;
assign tx_busy = (tx_cnt_reg != 4'h0);

always @(posedge clk) begin
    if (rst) begin
        tsr_reg <= 9'h000;
        tx_cnt_reg <= 4'h0;
        tx_out <= 1'b1;
        tx_done <= 1'b0;
    end else begin
        tx_done <= 1'b0;
        if (!tx_active) begin
            tx_cnt_reg <= 4'h0;
            tx_out <= 1'b1;
        end else if (tx_load) begin
            // LSB first, first bit driven at once
            tsr_reg <= {1'b0, tx_word[8:1]};
            tx_out <= tx_word[0];
            tx_cnt_reg <= tx_len;
        end else if (rise_stb && tx_busy) begin
            tx_cnt_reg <= tx_cnt_reg - 4'h1;
            if (tx_cnt_reg == 4'h1) begin
                tx_done <= 1'b1;
            end else begin
                tx_out <= tsr_reg[0];
                tsr_reg <= {1'b0, tsr_reg[8:1]};
            end
        end
    end
end

always @(posedge clk) begin
    if (rst) begin
        rsr_reg <= 9'h000;
        rx_cnt_reg <= 4'h0;
        rx_word <= 9'h000;
        rx_done <= 1'b0;
    end else begin
        rx_done <= 1'b0;
        if (!rx_active) begin
            rx_cnt_reg <= 4'h0;
        end else if (fall_stb) begin
            rsr_reg <= {data_in, rsr_reg[8:1]};
            if (rx_cnt_reg + 4'h1 == rx_len) begin
                rx_cnt_reg <= 4'h0;
                rx_done <= 1'b1;
                rx_word <= rx_nine ? {data_in, rsr_reg[8:1]} : {1'b0, data_in, rsr_reg[8:2]};
            end else begin
                rx_cnt_reg <= rx_cnt_reg + 4'h1;
            end
        end
    end
end

endmodule

// ==== hw/sync_slave_port.v ====
// Synchronous slave serial port: register file on classic Wishbone plus pin logic.
// Assumes an external master drives the shift clock pin; data pin is half-duplex.
//
// Our own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`include "sync_slave_map.vh"

module sync_slave_port (
    // Clock and reset
    input wire SYS_CLK,
    input wire RESET,
    // Wishbone slave
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [3:0] WB_ADR_I,
    input wire [7:0] WB_DAT_I,
    input wire WB_SEL_I,
    output reg [7:0] WB_DAT_O,
    output reg WB_ACK_O,
    // Serial pins
    input wire SHIFT_CLOCK_PIN_I,
    input wire SERIAL_DATA_PIN_I,
    output wire SERIAL_DATA_PIN_O,
    output wire SERIAL_DATA_PIN_OE,
    // Interrupt and wake
    output wire IRQ,
    output wire WAKE
);

reg [7:0] rxc_reg;
reg [7:0] txc_reg;
reg [7:0] baud_reg;
reg [7:0] div_hi_reg;
reg [7:0] div_lo_reg;
reg [7:0] irq_reg;
reg [7:0] tx_hold_reg;
reg tx_hold_nine_reg;
reg tx_hold_full_reg;
reg [7:0] rx_hold_reg;
reg rx_hold_nine_reg;
reg rx_hold_full_reg;
reg txif_reg;
reg [1:0] ck_sync_reg;
reg [1:0] dt_sync_reg;
reg ck_last_reg;
wire rise_stb;
wire fall_stb;
wire slave_mode;
wire tx_active;
wire rx_active;
wire tx_busy;
wire tx_done;
wire tx_out;
wire [8:0] rx_word;
wire rx_done;
wire tx_load;
wire wb_req;
wire wb_wr;
wire wb_rd;
wire rcif;

// Pin synchronisers; only second stage feeds logic
always @(posedge SYS_CLK) begin
    if (RESET) begin
        ck_sync_reg <= 2'b00;
        dt_sync_reg <= 2'b00;
        ck_last_reg <= 1'b0;
    end else begin
        ck_sync_reg <= {ck_sync_reg[0], SHIFT_CLOCK_PIN_I};
        dt_sync_reg <= {dt_sync_reg[0], SERIAL_DATA_PIN_I};
        ck_last_reg <= ck_sync_reg[1];
    end
end

// Edges found on the external clock pin only
assign rise_stb = slave_mode & ck_sync_reg[1] & ~ck_last_reg;
assign fall_stb = slave_mode & ~ck_sync_reg[1] & ck_last_reg;

// Same mode decode as master, clock source cleared
assign slave_mode = rxc_reg[`RXC_SERIAL_PORT_ENABLE] & txc_reg[`TXC_SYNC] & ~txc_reg[`TXC_CLOCK_SOURCE_SELECT];
assign tx_active = slave_mode & txc_reg[`TXC_TRANSMIT_ENABLE];
assign rx_active = slave_mode & rxc_reg[`RXC_CONTINUOUS_RECEIVE_ENABLE];

// Empty shift register takes the holding word at once
assign tx_load = tx_active & tx_hold_full_reg & (~tx_busy | tx_done);

// Half-duplex: drive whenever transmit is enabled and continuous receive is off, idle or shifting
assign SERIAL_DATA_PIN_O = tx_out;
assign SERIAL_DATA_PIN_OE = tx_active & ~rx_active;

sync_shift_engine u_engine (
    .clk(SYS_CLK),
    .rst(RESET),
    .rise_stb(rise_stb),
    .fall_stb(fall_stb),
    .data_in(dt_sync_reg[1]),
    .tx_active(tx_active),
    .tx_load(tx_load),
    .tx_word({tx_hold_nine_reg, tx_hold_reg}),
    .tx_nine(txc_reg[`TXC_TX9]),
    .tx_out(tx_out),
    .tx_busy(tx_busy),
    .tx_done(tx_done),
    .rx_active(rx_active),
    .rx_nine(rxc_reg[`RXC_RX9]),
    .rx_word(rx_word),
    .rx_done(rx_done)
);

assign wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
assign wb_wr = wb_req & WB_WE_I & WB_SEL_I;
assign wb_rd = wb_req & ~WB_WE_I;

// Wishbone answer: one cycle after the request, dropped next cycle
always @(posedge SYS_CLK) begin
    if (RESET) begin
        WB_ACK_O <= 1'b0;
        WB_DAT_O <= 8'h00;
    end else begin
        WB_ACK_O <= wb_req;
        if (wb_rd) begin
            case (WB_ADR_I)
                `ADDR_RX_STAT_CTRL: WB_DAT_O <= rxc_reg;
                `ADDR_TX_STAT_CTRL: WB_DAT_O <= {txc_reg[7:2], ~tx_busy, txc_reg[0]};
                `ADDR_BAUD_LINE: WB_DAT_O <= baud_reg;
                `ADDR_DIV_HIGH: WB_DAT_O <= div_hi_reg;
                `ADDR_DIV_LOW: WB_DAT_O <= div_lo_reg;
                `ADDR_RX_HOLD: WB_DAT_O <= rx_hold_reg;
                `ADDR_IRQ_CTRL: WB_DAT_O <= {irq_reg[7:2], rcif, txif_reg};
                default: WB_DAT_O <= 8'h00;
            endcase
        end
    end
end

assign rcif = rx_hold_full_reg;

// Control registers
always @(posedge SYS_CLK) begin
    if (RESET) begin
        rxc_reg <= `RST_RX_STAT_CTRL;
        txc_reg <= `RST_TX_STAT_CTRL;
        baud_reg <= `RST_BAUD_LINE;
        div_hi_reg <= `RST_DIVISOR;
        div_lo_reg <= `RST_DIVISOR;
        irq_reg <= `RST_IRQ_CTRL;
    end else begin
        if (wb_wr && WB_ADR_I == `ADDR_RX_STAT_CTRL) begin
            rxc_reg[7:3] <= WB_DAT_I[7:3];
            if (!WB_DAT_I[`RXC_CONTINUOUS_RECEIVE_ENABLE]) begin
                rxc_reg[`RXC_OERR] <= 1'b0;
                rxc_reg[`RXC_FERR] <= 1'b0;
            end
        end
        if (wb_wr && WB_ADR_I == `ADDR_TX_STAT_CTRL) begin
            txc_reg <= {WB_DAT_I[7:2], 1'b0, WB_DAT_I[0]};
        end
        if (wb_wr && WB_ADR_I == `ADDR_BAUD_LINE) begin
            baud_reg <= WB_DAT_I;
        end
        if (wb_wr && WB_ADR_I == `ADDR_DIV_HIGH) begin
            div_hi_reg <= WB_DAT_I;
        end
        if (wb_wr && WB_ADR_I == `ADDR_DIV_LOW) begin
            div_lo_reg <= WB_DAT_I;
        end
        if (wb_wr && WB_ADR_I == `ADDR_IRQ_CTRL) begin
            irq_reg[7:2] <= WB_DAT_I[7:2];
        end
        // Overrun: word completes while holding still full; set beats clear
        if (rx_done && rx_hold_full_reg && !(wb_rd && WB_ADR_I == `ADDR_RX_HOLD)) begin
            rxc_reg[`RXC_OERR] <= 1'b1;
        end
        // Ninth received bit beside the holding word
        if (rx_done && (!rx_hold_full_reg || (wb_rd && WB_ADR_I == `ADDR_RX_HOLD))) begin
            rxc_reg[`RXC_RECEIVE_NINTH_BIT] <= rx_word[8];
        end
    end
end

// Transmit holding and its flag
always @(posedge SYS_CLK) begin
    if (RESET) begin
        tx_hold_reg <= 8'h00;
        tx_hold_nine_reg <= 1'b0;
        tx_hold_full_reg <= 1'b0;
        txif_reg <= 1'b1;
    end else begin
        if (wb_wr && WB_ADR_I == `ADDR_TX_HOLD) begin
            tx_hold_reg <= WB_DAT_I;
            tx_hold_nine_reg <= txc_reg[`TXC_TRANSMIT_NINTH_BIT];
            tx_hold_full_reg <= 1'b1;
            txif_reg <= 1'b0;
        end else if (tx_load) begin
            // Holding freed into shift register, flag set in the same cycle
            tx_hold_full_reg <= 1'b0;
            txif_reg <= 1'b1;
        end
    end
end

// Receive holding; a new word wins over a read in the same cycle
always @(posedge SYS_CLK) begin
    if (RESET) begin
        rx_hold_reg <= 8'h00;
        rx_hold_nine_reg <= 1'b0;
        rx_hold_full_reg <= 1'b0;
    end else begin
        if (rx_done && (!rx_hold_full_reg || (wb_rd && WB_ADR_I == `ADDR_RX_HOLD))) begin
            rx_hold_reg <= rx_word[7:0];
            rx_hold_nine_reg <= rx_word[8];
            rx_hold_full_reg <= 1'b1;
        end else if (wb_rd && WB_ADR_I == `ADDR_RX_HOLD) begin
            rx_hold_full_reg <= 1'b0;
        end
    end
end

// Receiver stays armed while continuous receive set
// Runs on SYS_CLK sampling the pin edges, so stopping SYS_CLK stops it
assign WAKE = (txif_reg & irq_reg[`IRQ_TXIE]) | (rcif & irq_reg[`IRQ_RCIE]);
// Interrupt through global and peripheral enables
assign IRQ = WAKE & irq_reg[`IRQ_GIE] & irq_reg[`IRQ_PERIPHERAL_IRQ_ENABLE];

endmodule

// ==== sim/sync_slave_port_assertions.sv ====
// Checker for the synchronous slave port, bound to its top.
// Sees only top ports; shift clock watched through one local flop.
`timescale 1ns/1ps

module sync_slave_port_assertions (
    input wire SYS_CLK,
    input wire RESET,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [3:0] WB_ADR_I,
    input wire [7:0] WB_DAT_O,
    input wire WB_ACK_O,
    input wire SHIFT_CLOCK_PIN_I,
    input wire SERIAL_DATA_PIN_O,
    input wire SERIAL_DATA_PIN_OE,
    input wire IRQ,
    input wire WAKE
);
    logic ck_q;
    logic [4:0] age;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    // Cycles since a shift clock edge or bus answer
    always @(posedge SYS_CLK) begin
        ck_q <= SHIFT_CLOCK_PIN_I;
        if (RESET || WB_ACK_O || ck_q != SHIFT_CLOCK_PIN_I) begin
            age <= 5'h00;
        end else if (age != 5'h1F) begin
            age <= age + 5'h01;
        end
    end
    sequence bus_req;
        WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence
    sequence pin_moved;
        $changed(SERIAL_DATA_PIN_O) && SERIAL_DATA_PIN_OE && $past(SERIAL_DATA_PIN_OE);
    endsequence
    ack_next_a: assert property (bus_req |=> WB_ACK_O)
        else $error("Request not answered next cycle");
    ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("Answer longer than one cycle");
    ack_cause_a: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
        else $error("Answer without request");
    unmapped_zero_a: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I[3] |-> WB_DAT_O == 8'h00)
        else $error("Unmapped read not zero");
    oe_by_write_a: assert property ($changed(SERIAL_DATA_PIN_OE) |-> WB_ACK_O && WB_WE_I)
        else $error("Drive enable moved without write");
    pin_by_clock_a: assert property (pin_moved |-> WB_ACK_O || age < 5'h10)
        else $error("Data pin moved without shift clock");
    wake_rise_a: assert property ($rose(WAKE) |-> WB_ACK_O || age < 5'h10)
        else $error("Wake raised without cause");
    wake_fall_a: assert property ($fell(WAKE) |-> WB_ACK_O || $past(WB_ACK_O))
        else $error("Wake dropped without access");
    irq_gate_a: assert property (IRQ |-> WAKE)
        else $error("Interrupt without wake");
endmodule

bind sync_slave_port sync_slave_port_assertions chk_u (
    .SYS_CLK(SYS_CLK),
    .RESET(RESET),
    .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I),
    .WB_ADR_I(WB_ADR_I),
    .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O),
    .SHIFT_CLOCK_PIN_I(SHIFT_CLOCK_PIN_I),
    .SERIAL_DATA_PIN_O(SERIAL_DATA_PIN_O),
    .SERIAL_DATA_PIN_OE(SERIAL_DATA_PIN_OE),
    .IRQ(IRQ),
    .WAKE(WAKE)
);

// ==== sim/serial_master_model.sv ====
// External master that clocks the slave port's shift clock.
// Assumes the bench resolves the shared data wire into sdi.
`timescale 1ns/1ps

module serial_master_model (
    // Shift clock and data
    output logic sck,
    output logic sdo,
    input wire sdi
);
    initial begin
        sck = 1'b0;
        sdo = 1'b1;
    end
    task automatic frame(input int n, input logic [8:0] tx, output logic [8:0] rx);
        rx = 9'h000;
        #37;
        sdo = tx[0];
        #400;
        for (int i = 0; i < n; i++) begin
            rx[i] = sdi;
            sck = 1'b1;
            #400;
            // data held across the falling edge
            sck = 1'b0;
            #400;
            // Released wire shows the inverse, never a stale bit
            sdo = (i + 1 < n) ? tx[i + 1] : ~sdo;
        end
    endtask
endmodule

// ==== sim/tb.sv ====
// Self-checking bench for the synchronous slave port.
// Assumes the master model shares the data wire with the port.
`timescale 1ns/1ps

module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic sel = 1'b1;
    logic [3:0] adr = 4'h0;
    logic [7:0] dat = 8'h00;
    wire [7:0] dato;
    wire ack, sck, sdo, pin_o, pin_oe, irq, wake;
    wire line = pin_oe ? pin_o : sdo;
    int err_total = 0;
    int checked = 0;
    int seed;
    logic [15:0] notes[$];
    logic [8:0] got, w0, w1;

    always #50 clk = ~clk;

    sync_slave_port dut_u (.SYS_CLK(clk), .RESET(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_DAT_I(dat), .WB_SEL_I(sel), .WB_DAT_O(dato),
        .WB_ACK_O(ack), .SHIFT_CLOCK_PIN_I(sck), .SERIAL_DATA_PIN_I(line),
        .SERIAL_DATA_PIN_O(pin_o), .SERIAL_DATA_PIN_OE(pin_oe), .IRQ(irq), .WAKE(wake));
    serial_master_model far_u (.sck(sck), .sdo(sdo), .sdi(line));

    task automatic final_report;
        $display("Compares %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [8:0] g, input logic [8:0] e);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d, input logic s);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 40);
        if (n >= 40) begin
            err_total++;
            final_report();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        wb(1'b1, a, d, 1'b1);
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
        notes.push_back({m, e & m});
        wb(1'b0, a, 8'h00, 1'b1);
    endtask

    // Oldest note is matched against each read answer
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0 && notes.size() > 0) begin
            chk({1'b0, dato & notes[0][15:8]}, {1'b0, notes[0][7:0]});
            notes.delete(0);
        end
    end

    initial begin
        #2000000;
        err_total++;
        final_report();
    end

    initial begin
        seed = $urandom(13006);
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(4'h0, 8'h00, 8'hFF);
        rd(4'h2, 8'h02, 8'hFF);
        rd(4'h7, 8'h01, 8'hFF);
        rd(4'hB, 8'h00, 8'hFF);
        wb(1'b1, 4'h2, 8'hFF, 1'b0);
        rd(4'h2, 8'h02, 8'hFF);
        w1 = 9'($urandom_range(255));
        wr(4'h4, w1[7:0]);
        rd(4'h4, w1[7:0], 8'hFF);
        wr(4'h5, ~w1[7:0]);
        rd(4'h5, ~w1[7:0], 8'hFF);
        wr(4'h3, w1[7:0]);
        rd(4'h3, w1[7:0], 8'hFF);
        wr(4'h0, 8'h80);
        wr(4'h2, 8'h30);
        wr(4'h7, 8'hD0);
        w0 = 9'($urandom_range(255));
        w1 = 9'($urandom_range(255));
        wr(4'h1, w0[7:0]);
        wr(4'h1, w1[7:0]);
        rd(4'h7, 8'h00, 8'h01);
        chk({8'h00, wake}, 9'h000);
        rd(4'h2, 8'h00, 8'h02);
        far_u.frame(8, 9'h1FF, got);
        chk(got, w0);
        repeat (8) @(posedge clk);
        rd(4'h7, 8'h01, 8'h01);
        chk({7'h00, irq, wake}, 9'h003);
        far_u.frame(8, 9'h000, got);
        chk(got, w1);
        repeat (8) @(posedge clk);
        rd(4'h2, 8'h02, 8'h02);
        wr(4'h2, 8'h71);
        wr(4'h1, w0[7:0]);
        far_u.frame(9, 9'h000, got);
        chk(got, {1'b1, w0[7:0]});
        repeat (8) @(posedge clk);
        wr(4'h7, 8'hE0);
        chk({8'h00, wake}, 9'h000);
        wr(4'h2, 8'h10);
        wr(4'h0, 8'hE0);
        w0 = 9'($urandom_range(511));
        far_u.frame(9, w0, got);
        repeat (8) @(posedge clk);
        rd(4'h7, 8'h00, 8'h02);
        wr(4'h0, 8'hF0);
        far_u.frame(9, w0, got);
        repeat (8) @(posedge clk);
        chk({8'h00, wake}, 9'h001);
        rd(4'h7, 8'h02, 8'h02);
        rd(4'h0, {7'h78, w0[8]}, 8'hFF);
        rd(4'h6, w0[7:0], 8'hFF);
        rd(4'h7, 8'h00, 8'h02);
        w1 = 9'($urandom_range(511));
        far_u.frame(9, w1, got);
        far_u.frame(9, w0, got);
        repeat (8) @(posedge clk);
        rd(4'h0, 8'h02, 8'h02);
        rd(4'h6, w1[7:0], 8'hFF);
        wr(4'h0, 8'hE0);
        rd(4'h0, 8'h00, 8'h02);
        final_report();
    end
endmodule
